// ==== core/sfep_top.v ====
// Command decoder and self-timed sequencer for erase, program and protection.
`timescale 1ns/1ps
`include "sfep_defines.vh"

module sfep_top #(
  parameter TW = 16,
  parameter [TW-1:0] SECT_ERASE_CYC = `SFEP_SECT_ERASE_CYC,
  parameter [TW-1:0] PAGE_ERASE_CYC = `SFEP_PAGE_ERASE_CYC,
  parameter [TW-1:0] PROG_CYC = `SFEP_PROG_CYC
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  input wire wp_n_i,
  input wire page_256_i,
  input wire [`SFEP_SECT_MAP_W-1:0] prot_map_i,
  input wire [`SFEP_SECT_MAP_W-1:0] lock_map_i,
  output wire status_busy_o,
  output wire status_prot_o,
  output reg arr_erase_o,
  output reg [11:0] arr_first_page_o,
  output reg [11:0] arr_last_page_o,
  output reg arr_wr_o,
  output reg [11:0] arr_page_o,
  output reg [8:0] arr_byte_o,
  output reg [7:0] arr_data_o
);

  localparam S_IDLE = 3'h0;
  localparam S_ERASE = 3'h1;
  localparam S_ERWAIT = 3'h2;
  localparam S_PROG = 3'h3;
  localparam S_PGWAIT = 3'h4;
  localparam S_CHIP = 3'h5;

  localparam JOB_SECT = 2'h0;
  localparam JOB_PROG = 2'h1;
  localparam JOB_CHIP = 2'h2;

  localparam [7:0] WP_FILT = `SFEP_WP_FILT_CYC;

  wire frame_start;
  wire frame_end;
  wire byte_stb;
  wire [7:0] rx_byte;
  wire tmr_done;
  reg tmr_load;
  reg [TW-1:0] tmr_count;

  reg [2:0] state_q;
  reg [1:0] job_q;
  reg [4:0] sect_q;
  reg buf_sel_q;
  reg [8:0] prog_off_q;
  reg sw_prot_q;
  reg frame_ok_q;
  reg [2:0] nbytes_q;
  reg [31:0] hdr_q;
  reg [8:0] wr_off_q;
  reg wp_s1_q;
  reg wp_s2_q;
  reg wp_filt_n_q;
  reg [7:0] wp_cnt_q;
  reg wp_eff_q;
  reg [7:0] buf1_mem [0:`SFEP_BUF_LAST_264];
  reg [7:0] buf2_mem [0:`SFEP_BUF_LAST_264];

  wire [31:0] hdr_n = {hdr_q[23:0], rx_byte};
  wire [7:0] opcode = hdr_q[`SFEP_OPC_FIELD];
  wire is_prog = (opcode == `SFEP_OP_PROG_BUF1) || (opcode == `SFEP_OP_PROG_BUF2);
  wire [8:0] buf_last = page_256_i ? `SFEP_BUF_LAST_256 : `SFEP_BUF_LAST_264;
  wire prot_en = sw_prot_q | wp_eff_q;
  wire [11:0] cmd_page = page_256_i ? hdr_q[`SFEP_A256_PAGE] : hdr_q[`SFEP_A264_PAGE];
  wire [4:0] cmd_sect = sect_of(cmd_page);

  // Page to sector index: top four bits pick 1-15, else 0a or 0b.
  function [4:0] sect_of;
    input [11:0] pg;
    begin
      if (pg[`SFEP_PG_SECT] != 4'h0)
        sect_of = {1'b0, pg[`SFEP_PG_SECT]} + `SFEP_SECT_0B;
      else if (pg[`SFEP_PG_SUB] != 5'h00)
        sect_of = `SFEP_SECT_0B;
      else
        sect_of = `SFEP_SECT_0A;
    end
  endfunction

  // First page of a sector index.
  function [11:0] sect_first;
    input [4:0] idx;
    begin
      if (idx == `SFEP_SECT_0A)
        sect_first = 12'h000;
      else if (idx == `SFEP_SECT_0B)
        sect_first = `SFEP_PG_0B_FIRST;
      else
        sect_first = {idx[3:0] - 4'h1, `SFEP_PG_LOW_ZERO};
    end
  endfunction

  // Last page of a sector index.
  function [11:0] sect_last;
    input [4:0] idx;
    begin
      if (idx == `SFEP_SECT_0A)
        sect_last = `SFEP_PG_0A_LAST;
      else if (idx == `SFEP_SECT_0B)
        sect_last = {4'h0, `SFEP_PG_LOW_ONES};
      else
        sect_last = {idx[3:0] - 4'h1, `SFEP_PG_LOW_ONES};
    end
  endfunction

  // A sector is untouchable when locked down, or marked while protection is on.
  function blocked;
    input [4:0] idx;
    input en;
    begin
      blocked = lock_map_i[idx] | (en & prot_map_i[idx]);
    end
  endfunction

  sfep_spi_rx u_rx (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .cs_n_i(cs_n_i),
    .sck_i(sck_i),
    .si_i(si_i),
    .frame_start_o(frame_start),
    .frame_end_o(frame_end),
    .byte_stb_o(byte_stb),
    .byte_o(rx_byte)
  );

  sfep_timer #(
    .W(TW)
  ) u_tmr (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .done_o(tmr_done)
  );

  // Status is decoded straight from the sequencer and protection registers.
  assign status_busy_o = (state_q != S_IDLE);
  assign status_prot_o = prot_en;

  // Write-protect pin: synchronise, then filter out glitches shorter than the window.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wp_s1_q <= 1'b1;
      wp_s2_q <= 1'b1;
      wp_filt_n_q <= 1'b1;
      wp_cnt_q <= 8'h00;
      wp_eff_q <= 1'b0;
    end
    else if (ce_i)
    begin
      wp_s1_q <= wp_n_i;
      wp_s2_q <= wp_s1_q;
      if (wp_s2_q == wp_filt_n_q)
        wp_cnt_q <= 8'h00;
      else if (wp_cnt_q == WP_FILT - 8'h01)
      begin
        wp_filt_n_q <= wp_s2_q;
        wp_cnt_q <= 8'h00;
      end
      else
        wp_cnt_q <= wp_cnt_q + 8'h01;
      // The filtered level only reaches protection between cycles.
      if (state_q == S_IDLE)
        wp_eff_q <= ~wp_filt_n_q;
    end
  end

  // Frame capture: header bytes, then buffer offset tracking for programs.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      frame_ok_q <= 1'b0;
      nbytes_q <= 3'h0;
      hdr_q <= 32'h0000_0000;
      wr_off_q <= 9'h000;
    end
    else if (ce_i)
    begin
      if (frame_start)
      begin
        // Commands arriving while a cycle runs are refused whole.
        frame_ok_q <= (state_q == S_IDLE);
        nbytes_q <= 3'h0;
      end
      else if (byte_stb)
      begin
        if (nbytes_q != `SFEP_HDR_BYTES)
        begin
          hdr_q <= hdr_n;
          nbytes_q <= nbytes_q + 3'h1;
          if (nbytes_q == `SFEP_HDR_BYTES - 3'h1)
            wr_off_q <= page_256_i ? {1'b0, hdr_n[`SFEP_A256_OFF]} : hdr_n[`SFEP_A264_OFF];
        end
        else if (is_prog)
          wr_off_q <= (wr_off_q >= buf_last) ? 9'h000 : wr_off_q + 9'h001;
        // Trailing bytes of other commands change nothing.
      end
    end
  end

  // Buffer storage: data bytes of a program frame land at the running offset.
  always @(posedge clk_i)
  begin
    if (ce_i && byte_stb && frame_ok_q && !frame_start && nbytes_q == `SFEP_HDR_BYTES && is_prog)
    begin
      if (opcode == `SFEP_OP_PROG_BUF2)
        buf2_mem[wr_off_q] <= rx_byte;
      else
        buf1_mem[wr_off_q] <= rx_byte;
    end
  end

  // Timer load value and strobe follow the sequencer state.
  always @*
  begin
    tmr_load = 1'b0;
    tmr_count = PROG_CYC;
    if (state_q == S_ERASE)
    begin
      tmr_load = 1'b1;
      tmr_count = (job_q == JOB_PROG) ? PAGE_ERASE_CYC : SECT_ERASE_CYC;
    end
    else if (state_q == S_PROG && prog_off_q == buf_last)
      tmr_load = 1'b1;
  end

  // Sequencer: command launch at chip select rising, then self-timed cycles.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= S_IDLE;
      job_q <= JOB_SECT;
      sect_q <= `SFEP_SECT_0A;
      buf_sel_q <= 1'b0;
      prog_off_q <= 9'h000;
      sw_prot_q <= 1'b0;
      arr_erase_o <= 1'b0;
      arr_first_page_o <= 12'h000;
      arr_last_page_o <= 12'h000;
      arr_wr_o <= 1'b0;
      arr_page_o <= 12'h000;
      arr_byte_o <= 9'h000;
      arr_data_o <= 8'h00;
    end
    else if (ce_i)
    begin
      arr_erase_o <= 1'b0;
      arr_wr_o <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (frame_end && frame_ok_q && nbytes_q == `SFEP_HDR_BYTES)
          begin
            if (hdr_q == `SFEP_SEQ_CHIP_ERASE)
            begin
              job_q <= JOB_CHIP;
              sect_q <= `SFEP_SECT_0A;
              state_q <= S_CHIP;
            end
            else if (hdr_q == `SFEP_SEQ_PROT_EN)
              sw_prot_q <= 1'b1;
            else if (hdr_q == `SFEP_SEQ_PROT_DIS)
            begin
              if (wp_filt_n_q)
                sw_prot_q <= 1'b0;
            end
            else if (opcode == `SFEP_OP_SECT_ERASE && !blocked(cmd_sect, prot_en))
            begin
              // One sector only, whatever page inside it was named.
              job_q <= JOB_SECT;
              arr_first_page_o <= sect_first(cmd_sect);
              arr_last_page_o <= sect_last(cmd_sect);
              state_q <= S_ERASE;
            end
            else if (is_prog && !blocked(cmd_sect, prot_en))
            begin
              job_q <= JOB_PROG;
              buf_sel_q <= (opcode == `SFEP_OP_PROG_BUF2);
              arr_page_o <= cmd_page;
              arr_first_page_o <= cmd_page;
              arr_last_page_o <= cmd_page;
              state_q <= S_ERASE;
            end
          end
        end
        S_CHIP:
        begin
          if (blocked(sect_q, prot_en))
          begin
            // Protected or locked sectors are stepped over untouched.
            if (sect_q == `SFEP_SECT_LAST)
              state_q <= S_IDLE;
            else
              sect_q <= sect_q + 5'h01;
          end
          else
          begin
            arr_first_page_o <= sect_first(sect_q);
            arr_last_page_o <= sect_last(sect_q);
            state_q <= S_ERASE;
          end
        end
        S_ERASE:
        begin
          arr_erase_o <= 1'b1;
          state_q <= S_ERWAIT;
        end
        S_ERWAIT:
        begin
          if (tmr_done)
          begin
            if (job_q == JOB_PROG)
            begin
              prog_off_q <= 9'h000;
              state_q <= S_PROG;
            end
            else if (job_q == JOB_CHIP && sect_q != `SFEP_SECT_LAST)
            begin
              sect_q <= sect_q + 5'h01;
              state_q <= S_CHIP;
            end
            else
              state_q <= S_IDLE;
          end
        end
        S_PROG:
        begin
          // Buffer contents stream to the page one byte a cycle.
          arr_wr_o <= 1'b1;
          arr_byte_o <= prog_off_q;
          arr_data_o <= buf_sel_q ? buf2_mem[prog_off_q] : buf1_mem[prog_off_q];
          if (prog_off_q == buf_last)
            state_q <= S_PGWAIT;
          else
            prog_off_q <= prog_off_q + 9'h001;
        end
        S_PGWAIT:
        begin
          if (tmr_done)
            state_q <= S_IDLE;
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // sfep_top

// ==== core/sfep_defines.vh ====
// Constants for the serial flash erase, program and protection command block.
`ifndef SFEP_DEFINES_VH
`define SFEP_DEFINES_VH

// Opcodes and four-byte command sequences.
`define SFEP_OP_SECT_ERASE 8'h7C
`define SFEP_OP_PROG_BUF1 8'h82
`define SFEP_OP_PROG_BUF2 8'h85
`define SFEP_SEQ_CHIP_ERASE 32'hC794_809A
`define SFEP_SEQ_PROT_EN 32'h3D2A_7FA9
`define SFEP_SEQ_PROT_DIS 32'h3D2A_7F9A
`define SFEP_HDR_BYTES 3'h4
`define SFEP_OPC_FIELD 31:24

// Address fields of the three address bytes.
`define SFEP_A264_PAGE 20:9
`define SFEP_A264_OFF 8:0
`define SFEP_A256_PAGE 19:8
`define SFEP_A256_OFF 7:0
`define SFEP_PG_SECT 11:8
`define SFEP_PG_SUB 7:3

// Buffer last locations per page mode.
`define SFEP_BUF_LAST_264 9'h107
`define SFEP_BUF_LAST_256 9'h0FF

// Sector indices: 0 is part 0a, 1 is part 0b, s+1 is sector s.
`define SFEP_SECT_0A 5'h00
`define SFEP_SECT_0B 5'h01
`define SFEP_SECT_LAST 5'h10
`define SFEP_SECT_MAP_W 17
`define SFEP_PG_0A_LAST 12'h007
`define SFEP_PG_0B_FIRST 12'h008
`define SFEP_PG_LOW_ONES 8'hFF
`define SFEP_PG_LOW_ZERO 8'h00

// Clock and write-protect noise filter timing.
`define SFEP_CLK_PERIOD_NS 25
`define SFEP_WP_FILT_NS 100
`define SFEP_WP_FILT_CYC ((`SFEP_WP_FILT_NS + `SFEP_CLK_PERIOD_NS - 1) / `SFEP_CLK_PERIOD_NS)

// Default self-timed cycle lengths in clock cycles.
`define SFEP_SECT_ERASE_CYC 16'h0400
`define SFEP_PAGE_ERASE_CYC 16'h0100
`define SFEP_PROG_CYC 16'h0080

`endif

// ==== core/sfep_spi_rx.v ====
// Serial receiver: synchronises the link pins and assembles bytes MSB first.
`timescale 1ns/1ps
`include "sfep_defines.vh"

module sfep_spi_rx (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  output wire frame_start_o,
  output wire frame_end_o,
  output reg byte_stb_o,
  output reg [7:0] byte_o
);

  reg cs_n_s1_q;
  reg cs_n_s2_q;
  reg cs_n_s3_q;
  reg sck_s1_q;
  reg sck_s2_q;
  reg sck_s3_q;
  reg si_s1_q;
  reg si_s2_q;
  reg [2:0] bit_cnt_q;
  reg [6:0] shift_q;
  wire sck_rise;

  // Two-flop synchronisers plus one extra stage for edge finding.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cs_n_s1_q <= 1'b1;
      cs_n_s2_q <= 1'b1;
      cs_n_s3_q <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
      si_s1_q <= 1'b0;
      si_s2_q <= 1'b0;
    end
    else if (ce_i)
    begin
      cs_n_s1_q <= cs_n_i;
      cs_n_s2_q <= cs_n_s1_q;
      cs_n_s3_q <= cs_n_s2_q;
      sck_s1_q <= sck_i;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      si_s1_q <= si_i;
      si_s2_q <= si_s1_q;
    end
  end

  // Frame edges and serial clock rising edge, all from second stages onward.
  assign frame_start_o = ce_i & cs_n_s3_q & ~cs_n_s2_q;
  assign frame_end_o = ce_i & ~cs_n_s3_q & cs_n_s2_q;
  assign sck_rise = sck_s2_q & ~sck_s3_q;

  // Shift register; a byte completes on the eighth rising edge.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
      byte_stb_o <= 1'b0;
      byte_o <= 8'h00;
    end
    else if (ce_i)
    begin
      byte_stb_o <= 1'b0;
      if (cs_n_s2_q)
        bit_cnt_q <= 3'h0;
      else if (sck_rise)
      begin
        shift_q <= {shift_q[5:0], si_s2_q};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7)
        begin
          byte_o <= {shift_q, si_s2_q};
          byte_stb_o <= 1'b1;
        end
      end
    end
  end

endmodule // sfep_spi_rx

// ==== core/sfep_timer.v ====
// Down counter that times the self-timed erase and program cycles.
`timescale 1ns/1ps

module sfep_timer #(
  parameter W = 16
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire load_i,
  input wire [W-1:0] count_i,
  output reg done_o
);

  reg [W-1:0] cnt_q;

  // Load starts a count; done pulses for one cycle when it reaches zero.
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= {W{1'b0}};
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      if (load_i)
        cnt_q <= count_i;
      else if (cnt_q != {W{1'b0}})
      begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        if (cnt_q == {{(W-1){1'b0}}, 1'b1})
          done_o <= 1'b1;
      end
    end
  end

endmodule // sfep_timer

// ==== tb/sfep_host_model.sv ====
// Host-side serial link driver that frames commands for the bench.
`timescale 1ns/1ps

module sfep_host_model (
  input wire clk_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  logic [7:0] buf_q [0:15];

  // Idle link: deselected, clock resting low.
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end

  // Sends n bytes MSB first at a 200 ns bit period; data only moves while the clock is low.
  task automatic frame(input int n);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < n; i++)
      for (int b = 7; b >= 0; b--)
      begin
        @(posedge clk_i);
        sck_o <= 1'b0;
        si_o <= buf_q[i][b];
        repeat (4) @(posedge clk_i);
        sck_o <= 1'b1;
        repeat (3) @(posedge clk_i);
      end
    @(posedge clk_i);
    sck_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    si_o <= ~si_o;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // sfep_host_model

// ==== tb/sfep_top_sva.sv ====
// Concurrent property checker for the erase, program and protection block.
`timescale 1ns/1ps
`include "sfep_defines.vh"

module sfep_top_sva (
  input wire clk_i,
  input wire rst_n_i,
  input wire cs_n_i,
  input wire wp_n_i,
  input wire page_256_i,
  input wire [`SFEP_SECT_MAP_W-1:0] prot_map_i,
  input wire [`SFEP_SECT_MAP_W-1:0] lock_map_i,
  input wire status_busy_o,
  input wire status_prot_o,
  input wire arr_erase_o,
  input wire [11:0] arr_first_page_o,
  input wire [11:0] arr_last_page_o,
  input wire arr_wr_o,
  input wire [11:0] arr_page_o,
  input wire [8:0] arr_byte_o
);
  // Sector index of a page: 0 and 1 split sector zero, s+1 stands for sector s.
  function automatic [4:0] sect_of(input [11:0] p);
    sect_of = (p[11:8] != 4'h0) ? {1'b0, p[11:8]} + 5'h01 : {4'h0, p[7:3] != 5'h00};
  endfunction

  // Derived views: last buffer byte, erase span shape and whether the target is blocked.
  wire [8:0] last_w = page_256_i ? 9'h0FF : 9'h107;
  wire [11:0] fpg = arr_first_page_o;
  wire span_ok = (fpg[11:8] != 4'h0) ? (fpg[7:0] == 8'h00 && arr_last_page_o == {fpg[11:8], 8'hFF})
    : ((fpg == 12'h000 && arr_last_page_o == 12'h007) || (fpg == 12'h008 && arr_last_page_o == 12'h0FF));
  wire [4:0] sx = sect_of(fpg);
  wire blk = lock_map_i[sx] | (status_prot_o & prot_map_i[sx]);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Chip select has been released for a while before any cycle starts.
  sequence s_cs_high;
    $past(cs_n_i, 2) && $past(cs_n_i);
  endsequence
  // Write-protect held with no cycle running, long enough to pass sync and filter.
  sequence s_wp_idle;
    (!wp_n_i && !status_busy_o)[*8];
  endsequence

  AST_ERASE_PULSE: assert property (arr_erase_o |-> status_busy_o ##1 !arr_erase_o)
    else $error("erase pulse outside busy or too long");
  AST_WR_BUSY: assert property (arr_wr_o |-> status_busy_o && !arr_erase_o)
    else $error("array write outside a busy cycle");
  AST_WR_FIRST: assert property ($rose(arr_wr_o) |-> arr_byte_o == 9'h000)
    else $error("page write does not start at byte zero");
  AST_WR_STEP: assert property (arr_wr_o && arr_byte_o != last_w |=>
    arr_wr_o && arr_byte_o == $past(arr_byte_o) + 9'h001 && $stable(arr_page_o))
    else $error("page write not consecutive");
  AST_SPAN: assert property (arr_erase_o && arr_first_page_o != arr_last_page_o |-> span_ok)
    else $error("erase span is not one whole sector");
  AST_NOT_BLOCKED: assert property (arr_erase_o |-> !blk)
    else $error("erase of a blocked sector");
  AST_START_AFTER_CS: assert property ($rose(status_busy_o) |-> s_cs_high)
    else $error("cycle started without chip select release");
  AST_PROT_FROZEN: assert property (status_busy_o && $past(status_busy_o) |-> $stable(status_prot_o))
    else $error("protection changed during a cycle");
  AST_WP_APPLIED: assert property (s_wp_idle |=> status_prot_o)
    else $error("write-protect did not enable protection");
endmodule // sfep_top_sva

bind sfep_top sfep_top_sva u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .wp_n_i(wp_n_i),
  .page_256_i(page_256_i), .prot_map_i(prot_map_i), .lock_map_i(lock_map_i), .status_busy_o(status_busy_o),
  .status_prot_o(status_prot_o), .arr_erase_o(arr_erase_o), .arr_first_page_o(arr_first_page_o),
  .arr_last_page_o(arr_last_page_o), .arr_wr_o(arr_wr_o), .arr_page_o(arr_page_o), .arr_byte_o(arr_byte_o));

// ==== tb/sfep_top_test.sv ====
// Self-checking bench for the erase, program and protection command block.
`timescale 1ns/1ps
`include "sfep_defines.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("unexpected at %0t: got %h exp %h", $time, g, e); end end

module sfep_top_test;
  logic clk_i, rst_n_i, wp_n_i, page_256_i;
  logic [16:0] prot_map_i, lock_map_i;
  wire cs_n, sck, si, busy, prot, ers, wr;
  wire [11:0] fp, lp, pg;
  wire [8:0] by;
  wire [7:0] dt;
  logic [23:0] eq [$];
  logic [28:0] wq [$];
  int mismatches, compares, bcnt;

  // Short self-timed cycles keep whole-chip runs brief.
  sfep_top #(.SECT_ERASE_CYC(16'h0008), .PAGE_ERASE_CYC(16'h0008), .PROG_CYC(16'h0008)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .wp_n_i(wp_n_i), .page_256_i(page_256_i), .prot_map_i(prot_map_i), .lock_map_i(lock_map_i),
    .status_busy_o(busy), .status_prot_o(prot), .arr_erase_o(ers), .arr_first_page_o(fp),
    .arr_last_page_o(lp), .arr_wr_o(wr), .arr_page_o(pg), .arr_byte_o(by), .arr_data_o(dt));

  sfep_host_model u_host (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

  // Free-running 40 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Records every array erase and write, and counts busy cycles.
  always @(posedge clk_i)
  begin
    if (ers === 1'b1) eq.push_back({fp, lp});
    if (wr === 1'b1) wq.push_back({pg, by, dt});
    if (busy === 1'b1) bcnt++;
  end

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Waits, bounded, for a self-timed cycle to finish.
  task automatic idle();
    int t;
    t = 0;
    while (busy !== 1'b0 && t < 5000)
    begin
      @(posedge clk_i);
      t++;
    end
    if (t == 5000)
    begin
      mismatches++;
      end_of_test();
    end
  endtask

  // Loads a four-byte header, MSB byte first.
  task automatic put4(input logic [31:0] w);
    for (int k = 0; k < 4; k++) u_host.buf_q[k] = w[31 - 8 * k -: 8];
  endtask

  // Sends a frame of n bytes and waits for the resulting cycle.
  task automatic run(input int n);
    eq.delete();
    wq.delete();
    bcnt = 0;
    u_host.frame(n);
    idle();
  endtask

  // Erase span of sector index s: 0 and 1 split sector zero, s+1 is sector s.
  function automatic logic [23:0] span(input int s);
    if (s < 2) return s ? {12'h008, 12'h0FF} : {12'h000, 12'h007};
    return {4'(s - 1), 8'h00, 4'(s - 1), 8'hFF};
  endfunction

  // Erases one sector through a random address inside it; hit says whether an erase follows.
  task automatic erase_one(input int s, input bit m, input bit hit);
    logic [23:0] r;
    logic [11:0] p;
    r = span(s);
    p = r[23:12] + 12'($urandom % (r[11:0] - r[23:12] + 1));
    @(posedge clk_i);
    page_256_i <= m;
    put4({`SFEP_OP_SECT_ERASE, m ? {4'($urandom), p, 8'($urandom)} : {3'($urandom), p, 9'($urandom)}});
    run(4);
    `CHK(eq.size(), hit ? 1 : 0)
    if (hit) `CHK(eq[0], r)
    `CHK(bcnt != 0, hit)
  endtask

  // Chip erase with a trailing byte; unblocked sectors are erased in order.
  task automatic chip(input bit pon);
    logic [16:0] blk;
    logic [23:0] r;
    put4(`SFEP_SEQ_CHIP_ERASE);
    u_host.buf_q[4] = 8'($urandom);
    run(5);
    blk = lock_map_i | (pon ? prot_map_i : 17'h0_0000);
    for (int s = 0; s < 17; s++)
      if (!blk[s])
      begin
        r = eq.pop_front();
        `CHK(r, span(s))
      end
    `CHK(eq.size(), 0)
  endtask

  // Program through a buffer from offset off; the data must wrap and land in the page write.
  task automatic prog(input bit m, input logic [7:0] op, input logic [8:0] off, input int nd);
    logic [11:0] p;
    logic [8:0] last;
    logic [7:0] d [0:7];
    p = 12'($urandom);
    last = m ? `SFEP_BUF_LAST_256 : `SFEP_BUF_LAST_264;
    @(posedge clk_i);
    page_256_i <= m;
    put4({op, m ? {4'h0, p, off[7:0]} : {3'h0, p, off}});
    for (int k = 0; k < nd; k++)
    begin
      d[k] = 8'($urandom);
      u_host.buf_q[4 + k] = d[k];
    end
    run(4 + nd);
    `CHK(eq.size() == 1 && eq[0] === {p, p}, 1'b1)
    `CHK(wq.size(), int'(last) + 1)
    for (int k = 0; k < wq.size(); k++) `CHK(wq[k][28:8], {p, 9'(k)})
    for (int k = 0; k < nd; k++) `CHK(wq[(off + k) % (last + 1)][7:0], d[k])
  endtask

  // Main sequence.
  initial
  begin
    logic [4:0] s;
    rst_n_i = 1'b0;
    wp_n_i = 1'b1;
    page_256_i = 1'b0;
    prot_map_i = 17'h0_0000;
    lock_map_i = 17'h0_0000;
    mismatches = 0;
    compares = 0;
    void'($urandom(32'hcd28_a320));
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK({busy, prot}, 2'b00)
    // Boundary sectors, then random ones in both page modes with random lockdown.
    erase_one(0, 0, 1);
    erase_one(1, 1, 1);
    erase_one(16, 0, 1);
    lock_map_i <= 17'($urandom);
    // Let the new lockdown map settle before the expected hits are read from it.
    @(posedge clk_i);
    for (int i = 0; i < 10; i++)
    begin
      s = 5'($urandom % 17);
      erase_one(s, i[0], !lock_map_i[s]);
    end
    prot_map_i <= 17'($urandom) | 17'h0_0020;
    chip(0);
    put4(`SFEP_SEQ_PROT_EN);
    run(4);
    `CHK(prot, 1'b1)
    chip(1);
    lock_map_i <= 17'h0_0000;
    prot_map_i <= 17'h0_0020;
    erase_one(5, 0, 0);
    erase_one(6, 1, 1);
    put4(`SFEP_SEQ_PROT_DIS);
    run(4);
    `CHK(prot, 1'b0)
    prog(0, `SFEP_OP_PROG_BUF1, 9'h105, 5);
    prog(1, `SFEP_OP_PROG_BUF2, 9'h0FE, 4);
    // Write-protect forces protection and locks out the disable command.
    wp_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    `CHK(prot, 1'b1)
    put4(`SFEP_SEQ_PROT_DIS);
    run(4);
    `CHK(prot, 1'b1)
    wp_n_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    `CHK(prot, 1'b0)
    // Pin asserted during a chip erase takes hold only after the erase.
    put4(`SFEP_SEQ_CHIP_ERASE);
    u_host.frame(4);
    wp_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    `CHK({busy, prot}, 2'b10)
    idle();
    repeat (12) @(posedge clk_i);
    `CHK(prot, 1'b1)
    // Command protection does not survive a reset.
    wp_n_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    put4(`SFEP_SEQ_PROT_EN);
    run(4);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK(prot, 1'b0)
    end_of_test();
  end
endmodule // sfep_top_test
